// ### rtl/csi_out_cfg.v
// Purpose: Output configuration register bank for the camera-serial transmit.
// Assumes: One clock; strobes are one cycle and never both at once.
// Notes: Read data stands in the cycle after the read strobe only.
//
// Strobed register access was chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none
`include "csi_out_cfg_map.vh"

// Behaviour
// - Override bit clear: trail timing comes from the automatic value.
// - Override bit set: trail timing is the stored four-bit value.
// - Raw placement bit selects low or high lines of the colour bus.
// - Port 0 enable field resets to all ones; zero disables, all ones enables.
// - Port 1 enable field resets to zero; all ones enables it.
// - Bit 7 of each port register is a register-control switch, reset 0.
// - Routing bit 2 drives the check result out on general pin three.
// - Routing bit 1, reset 1, drives the check result on pin zero.
// - Routing bit 0 reads back the present check-result level.
// - Channel bits 7:6 set the virtual channel of every output packet.
module csi_out_cfg #(
    parameter TRAIL_W = 4
) (
    // Clock and reset.
    input wire clk,
    input wire nrst,
    // Register port.
    input wire [7:0] reg_addr,
    input wire [7:0] reg_wdata,
    input wire reg_wr,
    input wire reg_rd,
    output reg [7:0] reg_rdata,
    // Check-result signal from the pixel checker, asynchronous.
    input wire check_result,
    // Automatically derived trail timing from the transmit timing logic.
    input wire [TRAIL_W-1:0] auto_trail,
    // Configuration towards the transmitter.
    output reg [TRAIL_W-1:0] trail_value,
    output reg raw_msb_place,
    output reg port0_on,
    output reg port1_on,
    output reg port0_register_control,
    output reg port1_register_control,
    output reg [1:0] virtual_channel_field,
    // General pins carrying the check result, with their enables.
    output reg general_pin_zero_o,
    output reg general_pin_zero_oe,
    output reg general_pin_three_o,
    output reg general_pin_three_oe
);

    reg [7:0] clock_trail_ctrl_r;
    reg [7:0] raw_placement_ctrl_r;
    reg [7:0] output_port0_enable_r;
    reg [7:0] output_port1_enable_r;
    reg [7:0] check_result_routing_r;
    reg [7:0] virtual_channel_select_r;
    reg check_meta_r;
    reg check_sync_r;
    reg [7:0] rdata_nxt;
    reg [TRAIL_W-1:0] auto_meta_r;
    reg [TRAIL_W-1:0] auto_sync_r;

    // Two-flop synchronisers; the first stage feeds only the second.
    always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            check_meta_r <= 1'b0;
            check_sync_r <= 1'b0;
            auto_meta_r <= {TRAIL_W{1'b0}};
            auto_sync_r <= {TRAIL_W{1'b0}};
        end else begin
            check_meta_r <= check_result;
            check_sync_r <= check_meta_r;
            auto_meta_r <= auto_trail;
            auto_sync_r <= auto_meta_r;
        end
    end

    // Register writes. Unknown offsets are ignored so reserved space stays
    // untouched even if software misbehaves.
    always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            clock_trail_ctrl_r <= `RST_CLOCK_TRAIL;
            raw_placement_ctrl_r <= `RST_RAW_PLACE;
            output_port0_enable_r <= `RST_PORT0_EN;
            output_port1_enable_r <= `RST_PORT1_EN;
            check_result_routing_r <= `RST_CHECK_ROUTE;
            virtual_channel_select_r <= `RST_VCHAN;
        end else if (reg_wr) begin
            if (reg_addr == `OFS_CLOCK_TRAIL) begin
                clock_trail_ctrl_r <= reg_wdata;
            end else if (reg_addr == `OFS_RAW_PLACE) begin
                raw_placement_ctrl_r <= reg_wdata;
            end else if (reg_addr == `OFS_PORT0_EN) begin
                output_port0_enable_r <= reg_wdata;
            end else if (reg_addr == `OFS_PORT1_EN) begin
                output_port1_enable_r <= reg_wdata;
            end else if (reg_addr == `OFS_CHECK_ROUTE) begin
                // Bit 0 is status; the stored copy is never read back.
                check_result_routing_r <= reg_wdata;
            end else if (reg_addr == `OFS_VCHAN) begin
                virtual_channel_select_r <= reg_wdata;
            end
        end
    end

    // Read multiplexer; unmapped offsets read as zero.
    always @* begin
        rdata_nxt = 8'h00;
        if (reg_addr == `OFS_CLOCK_TRAIL) begin
            rdata_nxt = clock_trail_ctrl_r;
        end else if (reg_addr == `OFS_RAW_PLACE) begin
            rdata_nxt = raw_placement_ctrl_r;
        end else if (reg_addr == `OFS_PORT0_EN) begin
            rdata_nxt = output_port0_enable_r;
        end else if (reg_addr == `OFS_PORT1_EN) begin
            rdata_nxt = output_port1_enable_r;
        end else if (reg_addr == `OFS_CHECK_ROUTE) begin
            rdata_nxt = {check_result_routing_r[7:1], check_sync_r};
        end else if (reg_addr == `OFS_VCHAN) begin
            rdata_nxt = virtual_channel_select_r;
        end
    end

    // Read data is held only for the cycle after the strobe.
    always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            reg_rdata <= 8'h00;
        end else if (reg_rd) begin
            reg_rdata <= rdata_nxt;
        end else begin
            reg_rdata <= 8'h00;
        end
    end

    // Configuration outputs, registered so the transmitter sees clean levels.
    // Only the exact all-ones code enables a port; other codes are treated
    // as disabled since their meaning is undefined.
    always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            trail_value <= {TRAIL_W{1'b0}};
            raw_msb_place <= 1'b0;
            port0_on <= 1'b0;
            port1_on <= 1'b0;
            port0_register_control <= 1'b0;
            port1_register_control <= 1'b0;
            virtual_channel_field <= 2'b00;
        end else begin
            if (clock_trail_ctrl_r[`BIT_TRAIL_OVERRIDE]) begin
                trail_value <= clock_trail_ctrl_r[TRAIL_W-1:0];
            end else begin
                trail_value <= auto_sync_r;
            end
            raw_msb_place <= raw_placement_ctrl_r[`BIT_RAW_MSB];
            port0_on <= (output_port0_enable_r[5:0] == `PORT_EN_ALL);
            port1_on <= (output_port1_enable_r[5:0] == `PORT_EN_ALL);
            port0_register_control <=
                output_port0_enable_r[`BIT_REG_CONTROL];
            port1_register_control <=
                output_port1_enable_r[`BIT_REG_CONTROL];
            virtual_channel_field <= virtual_channel_select_r[7:6];
        end
    end

    // Check-result routing onto the general pins.
    always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            general_pin_zero_o <= 1'b0;
            general_pin_zero_oe <= 1'b0;
            general_pin_three_o <= 1'b0;
            general_pin_three_oe <= 1'b0;
        end else begin
            general_pin_zero_oe <= check_result_routing_r[`BIT_TO_PIN0];
            general_pin_zero_o <= check_result_routing_r[`BIT_TO_PIN0] &
                check_sync_r;
            general_pin_three_oe <= check_result_routing_r[`BIT_TO_PIN3];
            general_pin_three_o <= check_result_routing_r[`BIT_TO_PIN3] &
                check_sync_r;
        end
    end

endmodule
`default_nettype wire

// ### rtl/csi_out_cfg_map.vh
// Purpose: Offsets, field positions and reset values of the output config bank.
// Assumes: Eight-bit registers reached by a byte-wide indirect offset.
// Notes: Definitions only.
`ifndef CSI_OUT_CFG_MAP_VH
`define CSI_OUT_CFG_MAP_VH

// Register offsets.
`define OFS_CLOCK_TRAIL 8'h02
`define OFS_RAW_PLACE 8'h09
`define OFS_PORT0_EN 8'h13
`define OFS_PORT1_EN 8'h14
`define OFS_CHECK_ROUTE 8'h16
`define OFS_VCHAN 8'h2e

// Reset values.
`define RST_CLOCK_TRAIL 8'h00
`define RST_RAW_PLACE 8'h00
`define RST_PORT0_EN 8'h3f
`define RST_PORT1_EN 8'h00
`define RST_CHECK_ROUTE 8'h02
`define RST_VCHAN 8'h00

// Field positions.
`define BIT_TRAIL_OVERRIDE 7
`define BIT_RAW_MSB 4
`define BIT_REG_CONTROL 7
`define BIT_TO_PIN3 2
`define BIT_TO_PIN0 1
`define BIT_CHECK_STATUS 0

// Enable field codes.
`define PORT_EN_ALL 6'h3f

`endif

// ### verif/cfg_chk.sv
// Purpose: Port assertions for the output config bank.
// Assumes: One clock, asynchronous active-low reset.
// Notes: A write shows at the outputs two sampling edges later.
`timescale 1ns/100ps
`default_nettype none
module cfg_chk #(
    parameter TRAIL_W = 4
) (
    // Clock, reset and register port.
    input wire clk,
    input wire nrst,
    input wire [7:0] reg_addr,
    input wire [7:0] reg_wdata,
    input wire reg_wr,
    input wire reg_rd,
    input wire [7:0] reg_rdata,
    // Status input and configuration outputs.
    input wire check_result,
    input wire [TRAIL_W-1:0] trail_value,
    input wire raw_msb_place,
    input wire port0_on,
    input wire port1_on,
    input wire port0_register_control,
    input wire [1:0] virtual_channel_field,
    input wire general_pin_zero_o,
    input wire general_pin_zero_oe
);
    // One domain, so clock and reset are given once.
    default clocking @(posedge clk); endclocking
    default disable iff (!nrst);
    sequence wr_at(a);
        reg_wr && reg_addr == a;
    endsequence
    a_trail_override: assert property (
        (wr_at(8'h02) ##0 reg_wdata[7]) |->
        ##2 trail_value == $past(reg_wdata[TRAIL_W-1:0], 2))
        else $error("trail override value not applied");
    a_raw_place: assert property (
        wr_at(8'h09) |-> ##2 raw_msb_place == $past(reg_wdata[4], 2))
        else $error("raw placement wrong");
    a_port0_enable: assert property (
        wr_at(8'h13) |->
        ##2 port0_on == ($past(reg_wdata[5:0], 2) == 6'h3f))
        else $error("port 0 enable wrong");
    a_port1_enable: assert property (
        wr_at(8'h14) |->
        ##2 port1_on == ($past(reg_wdata[5:0], 2) == 6'h3f))
        else $error("port 1 enable wrong");
    a_reg_control: assert property (
        wr_at(8'h13) |->
        ##2 port0_register_control == $past(reg_wdata[7], 2))
        else $error("register control switch wrong");
    a_vchan_field: assert property (
        wr_at(8'h2e) |->
        ##2 virtual_channel_field == $past(reg_wdata[7:6], 2))
        else $error("virtual channel wrong");
    a_pin0_follow: assert property (
        general_pin_zero_oe && $past(nrst, 3) |->
        general_pin_zero_o == $past(check_result, 3))
        else $error("pin zero does not follow check result");
    a_unmapped_zero: assert property (
        reg_rd && !(reg_addr inside {8'h02, 8'h09, 8'h13, 8'h14,
        8'h16, 8'h2e}) |=> reg_rdata == 8'h00)
        else $error("unmapped read not zero");
endmodule
bind csi_out_cfg cfg_chk #(.TRAIL_W(TRAIL_W)) chk (.clk(clk),
    .nrst(nrst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .check_result(check_result), .trail_value(trail_value),
    .raw_msb_place(raw_msb_place), .port0_on(port0_on),
    .port1_on(port1_on), .port0_register_control(port0_register_control),
    .virtual_channel_field(virtual_channel_field),
    .general_pin_zero_o(general_pin_zero_o),
    .general_pin_zero_oe(general_pin_zero_oe));
`default_nettype wire

// ### verif/far_side.sv
// Purpose: Pixel checker and timing logic feeding the bank.
// Assumes: Driven from the core clock.
// Notes: The automatic trail value is a fixed code.
`timescale 1ns/100ps
`default_nettype none
module far_side #(
    parameter AUTO = 4'h9
) (
    // Clock and request from the bench.
    input wire logic clk,
    input wire logic pass_set,
    // Signals towards the bank.
    output var logic check_result,
    output logic [3:0] auto_trail
);
    // The result follows the request one clock later, low at start.
    initial check_result = 1'b0;
    always @(posedge clk) check_result <= pass_set;
    assign auto_trail = AUTO;
endmodule
`default_nettype wire

// ### verif/testbench.sv
// Purpose: Directed register tests of the output config bank.
// Assumes: Read data stands one cycle after the read strobe.
// Notes: Each write waits until its output has settled.
`timescale 1ns/100ps
`default_nettype none
module testbench;
    localparam logic [3:0] AUTO_T = 4'h9;
    logic clk, nrst, reg_wr, reg_rd, pass_set, chk_r, raw, p0, p1, c0, c1;
    logic [7:0] reg_addr, reg_wdata, reg_rdata;
    logic [3:0] auto_trail, trail;
    logic [1:0] vc;
    logic z_o, z_oe, t_o, t_oe;
    int mismatches, num_checks;
    // Core clock at 25 MHz.
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    far_side #(.AUTO(AUTO_T)) far (.clk(clk), .pass_set(pass_set),
        .check_result(chk_r), .auto_trail(auto_trail));
    csi_out_cfg uut (.clk(clk), .nrst(nrst), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .check_result(chk_r),
        .auto_trail(auto_trail), .trail_value(trail), .raw_msb_place(raw),
        .port0_on(p0), .port1_on(p1), .port0_register_control(c0),
        .port1_register_control(c1), .virtual_channel_field(vc),
        .general_pin_zero_o(z_o), .general_pin_zero_oe(z_oe),
        .general_pin_three_o(t_o), .general_pin_three_oe(t_oe));
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        num_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("wrong value at %0t: got %h, expected %h", $time, got,
                exp);
        end
    endtask
    // Write, then wait until the derived output has moved.
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_wr <= 1'b0;
        @(posedge clk);
        #1;
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        @(posedge clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1 chk(reg_rdata, exp);
    endtask
    task automatic close_out;
        $display("checks %0d, mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    // A hang counts as a mismatch.
    initial begin
        #100000;
        mismatches++;
        close_out;
    end
    initial begin
        {nrst, reg_wr, reg_rd, pass_set} = 4'h0;
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
        repeat (8) @(posedge clk);
        nrst <= 1'b1;
        rd(8'h13, 8'h3f);
        rd(8'h14, 8'h00);
        rd(8'h16, 8'h02);
        chk({4'h0, p0, p1, c0, z_oe}, 8'h09);
        $display("reset test done");
        wr(8'h09, 8'hff);
        chk({7'h0, raw}, 8'h01);
        rd(8'h09, 8'hff);
        wr(8'h13, 8'hbe);
        chk({6'h0, p0, c0}, 8'h01);
        wr(8'h14, 8'h3f);
        chk({7'h0, p1}, 8'h01);
        chk({7'h0, c1}, 8'h00);
        wr(8'h14, 8'h80);
        chk({6'h0, p1, c1}, 8'h01);
        rd(8'h03, 8'h00);
        wr(8'h02, 8'h6a);
        chk({4'h0, trail}, {4'h0, AUTO_T});
        wr(8'h02, 8'h8a);
        chk({4'h0, trail}, 8'h0a);
        for (int i = 0; i < 4; i++) begin
            wr(8'h2e, {2'(i), 6'h15});
            chk({6'h0, vc}, 8'(i));
        end
        $display("field test done");
        wr(8'h16, 8'h06);
        @(posedge clk);
        pass_set <= 1'b1;
        repeat (5) @(posedge clk);
        #1 chk({4'h0, z_o, z_oe, t_o, t_oe}, 8'h0f);
        rd(8'h16, 8'h07);
        wr(8'h16, 8'h00);
        chk({4'h0, z_o, z_oe, t_o, t_oe}, 8'h00);
        $display("routing test done");
        close_out;
    end
endmodule
`default_nettype wire
